// [bench/ddf_channel_props.sv]
// Port-level properties of the descriptor DMA channel, bound into every instance.
`timescale 1ns/1ps
`default_nettype none
module ddf_channel_props #(
  parameter logic [7:0] CHANNEL_ID = 8'h00
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [3:0] ext_flags,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic tx_valid,
  input wire logic rx_ready,
  input wire logic active,
  input wire logic [7:0] channel_status,
  input wire logic [31:0] cmd_ptr,
  input wire logic irq,
  input wire logic event_valid,
  input wire logic [15:0] event_data
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  AST_REQ_HOLD: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr)
    && $stable(mem_we) && $stable(mem_wdata)) else $error("request changed before ack");
  AST_REQ_GAP: assert property (mem_req && mem_ack |=> !mem_req)
    else $error("request not dropped after ack");
  AST_ADDR_WORD: assert property (mem_req |-> mem_addr[1:0] == 2'h0)
    else $error("unaligned memory address");
  AST_PTR_ALIGN: assert property (cmd_ptr[3:0] == 4'h0)
    else $error("descriptor pointer not 16-byte aligned");
  AST_STATUS_RSVD: assert property (mem_req && mem_we && mem_addr == cmd_ptr + 32'hC
    |-> mem_wdata[31:24] == 8'h00 && mem_wdata[15:0] == 16'h0000)
    else $error("status word reserved bits set");
  AST_IDLE_QUIET: assert property (!active |-> !mem_req && !tx_valid && !rx_ready)
    else $error("traffic while idle");
  AST_IRQ_ONCE: assert property (irq |-> $past(mem_ack) && $past(mem_we) ##1 !irq)
    else $error("interrupt not a single pulse after status write");
  AST_WAIT_SUSPEND: assert property (channel_status[5] |-> !mem_req)
    else $error("memory request while waiting");
  AST_STATUS_LATE: assert property (channel_status[3:0] == $past(ext_flags)
    && channel_status[4] == $past(active)) else $error("status bits wrong");
  AST_EVENT: assert property (ext_flags != $past(ext_flags) |=> event_valid
    && event_data[15:8] == CHANNEL_ID) else $error("missing event");
  AST_EVENT_CAUSE: assert property (event_valid |-> $past(ext_flags) != $past(ext_flags, 2))
    else $error("event without flag change");
endmodule : ddf_channel_props
`default_nettype wire

bind ddf_channel ddf_channel_props #(.CHANNEL_ID(CHANNEL_ID)) u_props (
  .core_clk(core_clk), .rst(rst), .ext_flags(ext_flags), .mem_req(mem_req),
  .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
  .tx_valid(tx_valid), .rx_ready(rx_ready), .active(active),
  .channel_status(channel_status), .cmd_ptr(cmd_ptr), .irq(irq),
  .event_valid(event_valid), .event_data(event_data));

// [bench/ddf_mem_model.sv]
// Behavioural system memory answering the channel's word accesses.
`timescale 1ns/1ps
`default_nettype none
module ddf_mem_model (
  input wire logic core_clk,
  input wire logic slow,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  logic [31:0] mem [0:1023];
  logic [2:0] wait_reg = 3'h0;
  wire logic [9:0] idx;
  wire logic ready;
  assign idx = mem_addr[11:2];
  assign ready = slow ? (wait_reg == 3'h3) : 1'b1;
  initial mem_ack = 1'b0;
  initial mem_rdata = 32'h0;
  // Between answers the read bus flips every cycle, so a stale sample cannot pass for data.
  always @(posedge core_clk) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    wait_reg <= 3'h0;
    if (mem_req && !mem_ack) begin
      wait_reg <= wait_reg + 3'h1;
      if (ready) begin
        mem_ack <= 1'b1;
        if (mem_we) mem[idx] <= mem_wdata;
        else mem_rdata <= mem[idx];
      end
    end
  end
endmodule : ddf_mem_model
`default_nettype wire

// [bench/testbench.sv]
// Self-checking bench for the descriptor DMA channel.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic run = 1'b0;
  logic cmd_ptr_load = 1'b0;
  logic [31:0] cmd_ptr_in = 32'h0;
  logic [3:0] ext_flags = 4'h0;
  logic [7:0] wait_mask = 8'h01;
  logic [7:0] wait_value = 8'h01;
  logic [7:0] branch_mask = 8'h01;
  logic [7:0] branch_value = 8'h00;
  logic mem_req, mem_we, mem_ack, tx_valid, rx_ready, active, irq, event_valid;
  logic [31:0] mem_addr, mem_wdata, mem_rdata, tx_data, cmd_ptr;
  logic [7:0] channel_status;
  logic [15:0] event_data;
  logic [15:0] evt_last = 16'h0000;
  logic tx_ready = 1'b1;
  logic rx_valid = 1'b1;
  logic [31:0] rx_data = 32'hA0B0C0D0;
  logic rx_hs = 1'b0;
  logic slow = 1'b0;
  logic [31:0] txq[$];
  int err_count = 0;
  int compares = 0;
  int irq_cnt = 0;
  int evt_cnt = 0;
  int cyc = 0;

  always #50 core_clk = ~core_clk;

  ddf_channel dut (.core_clk(core_clk), .rst(rst), .run(run), .cmd_ptr_load(cmd_ptr_load),
    .cmd_ptr_in(cmd_ptr_in), .ext_flags(ext_flags), .wait_mask(wait_mask),
    .wait_value(wait_value), .branch_mask(branch_mask), .branch_value(branch_value),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
    .active(active), .channel_status(channel_status), .cmd_ptr(cmd_ptr), .irq(irq),
    .event_valid(event_valid), .event_data(event_data));

  ddf_mem_model u_mem (.core_clk(core_clk), .slow(slow), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata));

  always @(posedge core_clk) begin
    cyc++;
    if (tx_valid && tx_ready) txq.push_back(tx_data);
    if (irq) irq_cnt++;
    if (event_valid) begin
      evt_cnt++;
      evt_last = event_data;
    end
    rx_hs <= rx_valid && rx_ready;
    if (cyc == 5000) begin
      err_count++;
      results();
    end
  end

  // The receive source offers a new word only after the previous one was taken.
  always @(negedge core_clk) if (rx_hs) rx_data <= rx_data + 32'h11111111;

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic put_desc(input logic [11:0] a, input logic [31:0] w0, input logic [31:0] w1,
                          input logic [31:0] w2);
    u_mem.mem[a[11:2]] = w0;
    u_mem.mem[a[11:2] + 10'h1] = w1;
    u_mem.mem[a[11:2] + 10'h2] = w2;
    u_mem.mem[a[11:2] + 10'h3] = 32'h5A5A5A5A;
  endtask : put_desc

  task automatic load_ptr(input logic [31:0] p);
    @(negedge core_clk);
    cmd_ptr_in = p;
    cmd_ptr_load = 1'b1;
    @(negedge core_clk);
    cmd_ptr_load = 1'b0;
  endtask : load_ptr

  // Run is dropped on the first idle cycle, before the channel can refetch a stop.
  task automatic run_until_idle();
    int n;
    n = 0;
    run = 1'b1;
    while (active !== 1'b1 && n < 10) begin
      @(negedge core_clk);
      n++;
    end
    while (active !== 1'b0 && n < 3000) begin
      @(negedge core_clk);
      n++;
    end
    run = 1'b0;
    chk("idle reached", 0, active);
  endtask : run_until_idle

  task automatic t_chain();
    put_desc(12'h100, 32'h00100008, 32'h00000203, 32'h0);
    put_desc(12'h110, 32'h200C0000, 32'h0, 32'h0000030B);
    put_desc(12'h300, 32'h10140006, 32'h00000401, 32'h00000325);
    put_desc(12'h310, 32'h30000000, 32'h0, 32'h0);
    put_desc(12'h320, 32'h30000000, 32'h0, 32'h0);
    u_mem.mem[10'h80] = 32'h44332211;
    u_mem.mem[10'h81] = 32'h88776655;
    load_ptr(32'h0000010D);
    chk("cmd_ptr load", 32'h100, cmd_ptr);
    run_until_idle();
    chk("tx count", 2, txq.size());
    if (txq.size() == 2) begin
      chk("tx word 0", 32'h44332211, txq[0]);
      chk("tx word 1", 32'h88776655, txq[1]);
    end
    chk("rx word 0", 32'hA0B0C0D0, u_mem.mem[10'h100]);
    chk("rx word 1", 32'hB1C1D1E1, u_mem.mem[10'h101]);
    chk("status 10C", 32'h00100000, u_mem.mem[10'h43]);
    chk("status 11C", 32'h00100000, u_mem.mem[10'h47]);
    chk("status 30C", 32'h00100000, u_mem.mem[10'hC3]);
    chk("skipped 31C", 32'h5A5A5A5A, u_mem.mem[10'hC7]);
    chk("final ptr", 32'h320, cmd_ptr);
    chk("irq count", 2, irq_cnt);
  endtask : t_chain

  task automatic t_wait();
    put_desc(12'h340, 32'h20090000, 32'h0, 32'h00000380);
    put_desc(12'h350, 32'h30000000, 32'h0, 32'h0);
    evt_cnt = 0;
    ext_flags = 4'h1;
    load_ptr(32'h340);
    repeat (3) @(negedge core_clk);
    chk("event count", 1, evt_cnt);
    chk("event data 1", 32'h00000001, evt_last);
    run = 1'b1;
    repeat (40) @(negedge core_clk);
    chk("waiting bit", 1, channel_status[5]);
    chk("status reg", 32'h00000031, channel_status);
    chk("wait ptr", 32'h340, cmd_ptr);
    chk("no status yet", 32'h5A5A5A5A, u_mem.mem[10'hD3]);
    ext_flags = 4'h0;
    run_until_idle();
    chk("wait status", 32'h00100000, u_mem.mem[10'hD3]);
    chk("event count", 2, evt_cnt);
    chk("event data 2", 32'h00000010, evt_last);
    chk("stop ptr", 32'h350, cmd_ptr);
  endtask : t_wait

  task automatic t_fifo();
    put_desc(12'h360, 32'h00000050, 32'h200, 32'h0);
    put_desc(12'h370, 32'hF0000000, 32'h0, 32'h0);
    for (int i = 0; i < 20; i++) u_mem.mem[128 + i] = 32'hC0DE0000 + i;
    txq.delete();
    slow = 1'b1;
    tx_ready = 1'b0;
    load_ptr(32'h360);
    run = 1'b1;
    repeat (300) @(negedge core_clk);
    chk("stalled count", 0, txq.size());
    tx_ready = 1'b1;
    run_until_idle();
    chk("drained count", 20, txq.size());
    chk("bad cmd ptr", 32'h00000370, cmd_ptr);
    foreach (txq[i]) chk("fifo word", 32'hC0DE0000 + i, txq[i]);
  endtask : t_fifo

  task automatic results();
    $display("Compares %0d errors %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : results

  initial begin
    repeat (16) @(negedge core_clk);
    chk("reset active", 0, active);
    chk("reset ptr", 0, cmd_ptr);
    chk("reset req", 0, mem_req);
    rst = 1'b0;
    t_chain();
    t_wait();
    t_fifo();
    results();
  end
endmodule : testbench
`default_nettype wire

// [inc/ddf_pkg.sv]
// Shared constants, descriptor layout and state type of the descriptor DMA channel.
package ddf_pkg;
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned STAT_W = 8;
  localparam int unsigned EXT_W = 4;
  localparam int unsigned CNT_W = 15;
  localparam int unsigned EVT_W = 16;
  localparam int unsigned FIFO_DEPTH = 16;

  // Descriptor geometry: one descriptor is four little-endian quadlets.
  localparam int unsigned DESC_BYTES = 16;
  localparam int unsigned WORD_BYTES = 4;
  localparam int unsigned DESC_FETCH_WORDS = 3;
  localparam int unsigned PTR_ALIGN_BITS = 4;
  localparam int unsigned DATA_ALIGN_BITS = 2;
  localparam logic [1:0] STATUS_WORD_IDX = 2'h3;

  // Fields of quadlet 0 of a descriptor.
  localparam int unsigned W0_COUNT_LSB = 0;
  localparam int unsigned COUNT_W = 16;
  localparam int unsigned W0_WAIT_LSB = 16;
  localparam int unsigned W0_BRANCH_LSB = 18;
  localparam int unsigned COND_W = 2;
  localparam int unsigned W0_IRQ_BIT = 20;
  localparam int unsigned W0_CMD_LSB = 28;
  localparam int unsigned CMD_W = 4;

  // Field of the status quadlet written back to memory.
  localparam int unsigned SW_STAT_LSB = 16;

  localparam logic [3:0] CMD_OUTPUT = 4'h0;
  localparam logic [3:0] CMD_INPUT = 4'h1;
  localparam logic [3:0] CMD_NOP = 4'h2;
  localparam logic [3:0] CMD_STOP = 4'h3;

  localparam logic [1:0] COND_NEVER = 2'h0;
  localparam logic [1:0] COND_TRUE = 2'h1;
  localparam logic [1:0] COND_FALSE = 2'h2;
  localparam logic [1:0] COND_ALWAYS = 2'h3;

  // Channel status bit positions; bits 3..0 are the external flags.
  localparam int unsigned STAT_ACTIVE_BIT = 4;
  localparam int unsigned STAT_WAIT_BIT = 5;

  localparam logic [31:0] PTR_RESET = 32'h00000000;
  localparam logic [31:0] WORD_RESET = 32'h00000000;
  localparam logic [7:0] STAT_RESET = 8'h00;

  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_FETCH = 6'b000010,
    ST_WAIT = 6'b000100,
    ST_XFER = 6'b001000,
    ST_STATUS = 6'b010000,
    ST_NEXT = 6'b100000
  } ddf_state_t;
endpackage : ddf_pkg

// [rtl/ddf_channel.sv]
// Descriptor-driven DMA channel: fetch, wait, stream transfer, status write and branch.
// Operation
// - Descriptors are fixed 16-byte units
// - At most one interrupt per operation
// - Commands read from, status written to memory
// - Linear descriptor array, branch for jumps
// - One independent channel per data path
// - Optional event reporting of asynchronous changes
// - Wait condition on status suspends channel
// - Input, output, no-op carry conditional branch
// - Target only executes initiator-built commands
// - Little-endian bytes in every quadlet
// - Reserved fields written zero, ignored read
// - Next descriptor pointer 16-byte aligned
// - Low pointer bits treated as reserved
`timescale 1ns/1ps
`default_nettype none
module ddf_channel #(
  parameter logic [7:0] CHANNEL_ID = 8'h00,
  parameter int unsigned FIFO_DEPTH = ddf_pkg::FIFO_DEPTH,
  parameter bit EVENT_EN = 1'b1
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic run,
  input wire logic cmd_ptr_load,
  input wire logic [ddf_pkg::ADDR_W-1:0] cmd_ptr_in,
  input wire logic [ddf_pkg::EXT_W-1:0] ext_flags,
  input wire logic [ddf_pkg::STAT_W-1:0] wait_mask,
  input wire logic [ddf_pkg::STAT_W-1:0] wait_value,
  input wire logic [ddf_pkg::STAT_W-1:0] branch_mask,
  input wire logic [ddf_pkg::STAT_W-1:0] branch_value,
  output logic mem_req,
  output logic mem_we,
  output logic [ddf_pkg::ADDR_W-1:0] mem_addr,
  output logic [ddf_pkg::DATA_W-1:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [ddf_pkg::DATA_W-1:0] mem_rdata,
  output logic tx_valid,
  output logic [ddf_pkg::DATA_W-1:0] tx_data,
  input wire logic tx_ready,
  input wire logic rx_valid,
  input wire logic [ddf_pkg::DATA_W-1:0] rx_data,
  output logic rx_ready,
  output logic active,
  output logic [ddf_pkg::STAT_W-1:0] channel_status,
  output logic [ddf_pkg::ADDR_W-1:0] cmd_ptr,
  output logic irq,
  output logic event_valid,
  output logic [ddf_pkg::EVT_W-1:0] event_data
);
  localparam logic [1:0] LAST_FETCH_IDX = 2'(ddf_pkg::DESC_FETCH_WORDS - 1);
  localparam logic [ddf_pkg::ADDR_W-1:0] DESC_STEP = ddf_pkg::ADDR_W'(ddf_pkg::DESC_BYTES);
  localparam logic [ddf_pkg::ADDR_W-1:0] WORD_STEP = ddf_pkg::ADDR_W'(ddf_pkg::WORD_BYTES);
  localparam int unsigned PA = ddf_pkg::PTR_ALIGN_BITS;
  localparam int unsigned DA = ddf_pkg::DATA_ALIGN_BITS;

  ddf_pkg::ddf_state_t state_reg;
  ddf_pkg::ddf_state_t state_next;

  logic [ddf_pkg::ADDR_W-1:0] ptr_reg;
  logic [ddf_pkg::ADDR_W-1:0] ptr_next;
  logic [ddf_pkg::DATA_W-1:0] w0_reg;
  logic [ddf_pkg::ADDR_W-1:0] data_addr_reg;
  logic [ddf_pkg::ADDR_W-1:0] branch_addr_reg;
  logic [1:0] word_idx_reg;
  logic [ddf_pkg::CNT_W-1:0] fill_cnt_reg;
  logic [ddf_pkg::CNT_W-1:0] drain_cnt_reg;
  logic mem_req_reg;
  logic mem_we_reg;
  logic [ddf_pkg::ADDR_W-1:0] mem_addr_reg;
  logic [ddf_pkg::DATA_W-1:0] mem_wdata_reg;
  logic irq_reg;
  logic event_valid_reg;
  logic [ddf_pkg::EVT_W-1:0] event_data_reg;
  logic [ddf_pkg::EXT_W-1:0] ext_prev_reg;
  logic [ddf_pkg::STAT_W-1:0] status_reg;

  // One masked compare serves both tests; the code picks never, match, mismatch or always.
  function automatic logic cond_eval(input logic [1:0] code,
                                     input logic [ddf_pkg::STAT_W-1:0] st,
                                     input logic [ddf_pkg::STAT_W-1:0] mask,
                                     input logic [ddf_pkg::STAT_W-1:0] value);
    logic match;
    match = ((st ^ value) & mask) == '0;
    case (code)
      ddf_pkg::COND_NEVER: cond_eval = 1'b0;
      ddf_pkg::COND_TRUE: cond_eval = match;
      ddf_pkg::COND_FALSE: cond_eval = !match;
      default: cond_eval = 1'b1;
    endcase
  endfunction : cond_eval

  // Descriptor fields; everything outside them is reserved and ignored.
  wire [ddf_pkg::CMD_W-1:0] cmd_code = w0_reg[ddf_pkg::W0_CMD_LSB +: ddf_pkg::CMD_W];
  wire [1:0] wait_code = w0_reg[ddf_pkg::W0_WAIT_LSB +: ddf_pkg::COND_W];
  wire [1:0] branch_code = w0_reg[ddf_pkg::W0_BRANCH_LSB +: ddf_pkg::COND_W];
  wire irq_en = w0_reg[ddf_pkg::W0_IRQ_BIT];
  wire [ddf_pkg::COUNT_W-1:0] req_bytes = w0_reg[ddf_pkg::W0_COUNT_LSB +: ddf_pkg::COUNT_W];
  // A partial last quadlet still costs a whole word access.
  wire [ddf_pkg::COUNT_W:0] bytes_rounded = {1'b0, req_bytes} + 17'h00003;
  wire [ddf_pkg::CNT_W-1:0] total_words = bytes_rounded[ddf_pkg::COUNT_W:DA];

  wire is_output = cmd_code == ddf_pkg::CMD_OUTPUT;
  wire is_input = cmd_code == ddf_pkg::CMD_INPUT;
  wire is_nop = cmd_code == ddf_pkg::CMD_NOP;
  // Unknown command codes halt the channel like a stop, so a bad list cannot run wild.
  wire is_stop = !(is_output || is_input || is_nop);

  wire st_idle = state_reg == ddf_pkg::ST_IDLE;
  wire st_fetch = state_reg == ddf_pkg::ST_FETCH;
  wire st_wait = state_reg == ddf_pkg::ST_WAIT;
  wire st_xfer = state_reg == ddf_pkg::ST_XFER;
  wire st_status = state_reg == ddf_pkg::ST_STATUS;
  wire st_next = state_reg == ddf_pkg::ST_NEXT;

  // Condition bits exclude the waiting flag so the wait test has no loop.
  wire [ddf_pkg::STAT_W-1:0] cond_vec = {3'b000, !st_idle, ext_flags};
  wire wait_hit = cond_eval(wait_code, cond_vec, wait_mask, wait_value);
  wire branch_hit = cond_eval(branch_code, cond_vec, branch_mask, branch_value);
  wire waiting = st_wait && wait_hit;
  wire [ddf_pkg::STAT_W-1:0] status_vec = {2'b00, waiting, !st_idle, ext_flags};

  // Stream FIFO hookup; its direction follows the current command.
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [ddf_pkg::DATA_W-1:0] fifo_out_data;
  wire fill_left = fill_cnt_reg != total_words;
  wire drain_left = drain_cnt_reg != total_words;
  wire rx_take = st_xfer && is_input && fill_left && fifo_in_ready;
  wire rd_ack = st_xfer && is_output && mem_req_reg && !mem_we_reg && mem_ack;
  wire fifo_push = rd_ack || (rx_take && rx_valid);
  wire [ddf_pkg::DATA_W-1:0] fifo_in_data = is_output ? mem_rdata : rx_data;
  wire tx_fire = st_xfer && is_output && fifo_out_valid && tx_ready;

  // One read outstanding at most, so free space at issue guarantees room at the ack.
  wire issue_read = st_xfer && is_output && !mem_req_reg && fill_left && fifo_in_ready;
  wire issue_write = st_xfer && is_input && !mem_req_reg && drain_left && fifo_out_valid;
  wire fifo_pop = tx_fire || issue_write;
  wire xfer_done = st_xfer && !drain_left && !mem_req_reg;

  wire issue_fetch = st_fetch && !mem_req_reg;
  wire fetch_last = st_fetch && mem_ack && (word_idx_reg == LAST_FETCH_IDX);
  wire wait_exit = st_wait && run && !is_stop && !wait_hit;
  wire go_xfer = wait_exit && (is_output || is_input);
  wire go_status = (wait_exit && is_nop) || xfer_done;
  // Fetch, data and status accesses share one request port and never overlap.
  wire mem_issue = issue_fetch || issue_read || issue_write || go_status;

  // Memory addresses never use the reserved low pointer bits.
  wire [ddf_pkg::ADDR_W-1:0] desc_base = {ptr_reg[ddf_pkg::ADDR_W-1:PA], PA'(0)};
  wire [ddf_pkg::ADDR_W-1:0] fetch_addr = desc_base | {28'h0000000, word_idx_reg, 2'b00};
  wire [ddf_pkg::ADDR_W-1:0] status_addr = desc_base
                                         | {28'h0000000, ddf_pkg::STATUS_WORD_IDX, 2'b00};
  wire [ddf_pkg::ADDR_W-1:0] data_addr = {data_addr_reg[ddf_pkg::ADDR_W-1:DA], DA'(0)};
  wire [ddf_pkg::ADDR_W-1:0] addr_sel = issue_fetch ? fetch_addr
                                      : go_status ? status_addr : data_addr;
  // Status quadlet: residual count zero, channel status above, reserved bits zero.
  wire [ddf_pkg::DATA_W-1:0] status_word = {8'h00, status_vec, 16'h0000};
  wire [ddf_pkg::DATA_W-1:0] wdata_sel = go_status ? status_word : fifo_out_data;

  // Flushing on entry to a transfer keeps words of an abandoned command out of the next.
  // Only one instance serves one data path; sibling paths get their own channel.
  ddf_fifo #(
    .WIDTH(ddf_pkg::DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .rst(rst),
    .clear(go_xfer),
    .in_valid(fifo_push),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data)
  );

  // Run is looked at only between commands, so a transfer in flight always finishes.
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ddf_pkg::ST_IDLE: begin
        if (run) begin
          state_next = ddf_pkg::ST_FETCH;
        end
      end
      ddf_pkg::ST_FETCH: begin
        if (fetch_last) begin
          state_next = ddf_pkg::ST_WAIT;
        end
      end
      ddf_pkg::ST_WAIT: begin
        if (!run || is_stop) begin
          state_next = ddf_pkg::ST_IDLE;
        end else if (go_xfer) begin
          state_next = ddf_pkg::ST_XFER;
        end else if (go_status) begin
          state_next = ddf_pkg::ST_STATUS;
        end
      end
      ddf_pkg::ST_XFER: begin
        if (xfer_done) begin
          state_next = ddf_pkg::ST_STATUS;
        end
      end
      ddf_pkg::ST_STATUS: begin
        if (mem_ack) begin
          state_next = ddf_pkg::ST_NEXT;
        end
      end
      ddf_pkg::ST_NEXT: begin
        state_next = run ? ddf_pkg::ST_FETCH : ddf_pkg::ST_IDLE;
      end
    endcase
  end

  // Sequential walk through the list unless the embedded branch is taken.
  always_comb begin
    ptr_next = ptr_reg;
    if (st_idle && cmd_ptr_load) begin
      ptr_next = {cmd_ptr_in[ddf_pkg::ADDR_W-1:PA], PA'(0)};
    end else if (st_next && branch_hit) begin
      ptr_next = {branch_addr_reg[ddf_pkg::ADDR_W-1:PA], PA'(0)};
    end else if (st_next) begin
      ptr_next = desc_base + DESC_STEP;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_reg <= ddf_pkg::ST_IDLE;
      ptr_reg <= ddf_pkg::PTR_RESET;
    end else begin
      state_reg <= state_next;
      ptr_reg <= ptr_next;
    end
  end

  // Descriptor capture; quadlets arrive least significant byte first.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      w0_reg <= ddf_pkg::WORD_RESET;
      branch_addr_reg <= ddf_pkg::PTR_RESET;
      word_idx_reg <= 2'h0;
    end else if (st_fetch && mem_ack) begin
      word_idx_reg <= fetch_last ? 2'h0 : word_idx_reg + 2'h1;
      if (word_idx_reg == 2'h0) begin
        w0_reg <= mem_rdata;
      end
      if (word_idx_reg == 2'h2) begin
        branch_addr_reg <= mem_rdata;
      end
    end
  end

  // The data address walks one quadlet per access; its low bits never reach the bus.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      data_addr_reg <= ddf_pkg::PTR_RESET;
    end else if (st_fetch && mem_ack && word_idx_reg == 2'h1) begin
      data_addr_reg <= mem_rdata;
    end else if (issue_read || issue_write) begin
      data_addr_reg <= data_addr + WORD_STEP;
    end
  end

  // Fill counts words requested or accepted, drain counts words handed on.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      fill_cnt_reg <= '0;
      drain_cnt_reg <= '0;
    end else if (go_xfer) begin
      fill_cnt_reg <= '0;
      drain_cnt_reg <= '0;
    end else begin
      if (issue_read || (rx_take && rx_valid)) begin
        fill_cnt_reg <= fill_cnt_reg + 1'b1;
      end
      if (fifo_pop) begin
        drain_cnt_reg <= drain_cnt_reg + 1'b1;
      end
    end
  end

  // The request is held until the memory answers with a one-cycle ack.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mem_req_reg <= 1'b0;
      mem_we_reg <= 1'b0;
      mem_addr_reg <= ddf_pkg::PTR_RESET;
      mem_wdata_reg <= ddf_pkg::WORD_RESET;
    end else if (mem_issue) begin
      mem_req_reg <= 1'b1;
      mem_we_reg <= issue_write || go_status;
      mem_addr_reg <= addr_sel;
      mem_wdata_reg <= wdata_sel;
    end else if (mem_ack) begin
      mem_req_reg <= 1'b0;
    end
  end

  // The processor hears of a command only once, when its status is in memory.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= st_status && mem_ack && irq_en;
    end
  end

  // Flag changes are reported with the channel number for a shared event channel.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ext_prev_reg <= '0;
      event_valid_reg <= 1'b0;
      event_data_reg <= '0;
      status_reg <= ddf_pkg::STAT_RESET;
    end else begin
      ext_prev_reg <= ext_flags;
      event_valid_reg <= EVENT_EN && (ext_flags != ext_prev_reg);
      event_data_reg <= {CHANNEL_ID, status_vec};
      // The visible status lags the live vector by one cycle, unlike active and the stream handshake outputs.
      status_reg <= status_vec;
    end
  end

  // Stream handshake outputs are decoded from state; the memory request and data outputs come from registers.
  assign mem_req = mem_req_reg;
  assign mem_we = mem_we_reg;
  assign mem_addr = mem_addr_reg;
  assign mem_wdata = mem_wdata_reg;
  assign tx_valid = st_xfer && is_output && fifo_out_valid;
  assign tx_data = fifo_out_data;
  assign rx_ready = rx_take;
  assign active = !st_idle;
  assign channel_status = status_reg;
  assign cmd_ptr = ptr_reg;
  assign irq = irq_reg;
  assign event_valid = event_valid_reg;
  assign event_data = event_data_reg;
endmodule : ddf_channel
`default_nettype wire

// [rtl/ddf_fifo.sv]
// Synchronous FIFO that buffers the stream words of one channel.
`timescale 1ns/1ps
`default_nettype none
module ddf_fifo #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 16
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_array [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  wire push;
  wire pop;

  assign in_ready = count_reg != FULL_COUNT;
  assign out_valid = count_reg != '0;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_array[rd_ptr_reg];

  // Storage is left unreset; only the pointers and the count say what is valid.
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_array[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else if (clear) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == LAST_PTR) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == LAST_PTR) ? '0 : rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : ddf_fifo
`default_nettype wire
